//--- logic/sesr_map.vh
/*
 Constants for the standard event status latch: bit positions, widths, reset values.
 Assumes inclusion by the latch top and its summary submodule.
*/
`ifndef SESR_MAP_VH
`define SESR_MAP_VH

// ======================================================================
// Field layout
`define SESR_WIDTH          16
`define SESR_EVT_WIDTH      8
`define SESR_BIT_OPC        0
`define SESR_BIT_RQC        1
`define SESR_BIT_QYE        2
`define SESR_BIT_DDE        3
`define SESR_BIT_EXE        4
`define SESR_BIT_CME        5
`define SESR_BIT_URQ        6
`define SESR_BIT_PON        7
`define SESR_STB_SUM_BIT    5

// ======================================================================
// Reset values
// Power-on bit is set at the first edge after release, not during reset
`define SESR_EVT_RESET      8'h00
`define SESR_ENA_RESET      8'h00
`define SESR_RESERVED_VAL   8'h00

`endif

//--- logic/sesr_summary.v
/*
 Summary bit of the event latch: any latched event whose enable bit is set.
 Assumes latch and enable come from registers on the same clock.
*/
`include "sesr_map.vh"
`default_nettype none

module sesr_summary #(
	parameter W = `SESR_EVT_WIDTH
) (
	// Inputs
	input  wire [W-1:0] events_i,
	input  wire [W-1:0] enable_i,
	// Output
	output wire         summary_o
);

	// ======================================================================
	// Masked OR
	assign summary_o = |(events_i & enable_i);

endmodule

`default_nettype wire

//--- logic/sesr_event_latch.v
/*
 Standard event status latch: sticky event bits, query read with clear,
 clear-status, enable mask and status-byte summary.
 Assumes event and command strobes are one-cycle pulses from logic on clock_i.
 Assumes the request-control and idle inputs are levels from the same clock.
 No input synchronisers: every source is logic on clock_i.
 Reset release stands in for a power cycle, so the power-on bit is set
 at the first clock edge after sys_rst_i falls.
*/
`include "sesr_map.vh"
`default_nettype none

module sesr_event_latch (
	// Clock and reset
	input  wire        clock_i,
	input  wire        sys_rst_i,
	// Event sources
	input  wire        cmd_syntax_err_i,
	input  wire        cmd_semantic_err_i,
	input  wire        trig_in_msg_i,
	input  wire        exe_range_err_i,
	input  wire        exe_hw_err_i,
	input  wire        dev_err_i,
	input  wire        qry_no_data_i,
	input  wire        qry_lost_i,
	input  wire        req_ctrl_i,
	input  wire        opc_cmd_i,
	input  wire        ops_idle_i,
	// Commands
	input  wire        esr_query_i,
	input  wire        cls_cmd_i,
	input  wire        ena_wr_i,
	input  wire [7:0]  ena_data_i,
	// Answers
	output reg         resp_valid_o,
	output reg  [15:0] resp_data_o,
	output wire [15:0] event_status_latch_o,
	output wire [7:0]  enable_o,
	output wire        stb_summary_o
);

	// ======================================================================
	// State
	reg  [7:0]  evt_r;
	reg  [7:0]  evt_nxt;
	reg  [7:0]  ena_r;
	reg  [7:0]  ena_nxt;
	reg         opc_arm_r;
	reg         opc_arm_nxt;
	reg         opc_live;
	reg         opc_done_nxt;
	reg         pon_seen_r;
	reg         resp_valid_nxt;
	reg  [15:0] resp_data_nxt;

	// ======================================================================
	// Functions
	// Reserved byte above the event byte keeps every answer within 0 to 255
	function [15:0] pack_word;
		input [7:0] evt;
		begin
			pack_word = {`SESR_RESERVED_VAL, evt};
		end
	endfunction

	// Sets one event bit when its cause is present; never clears one
	function [7:0] set_bit;
		input [7:0] val;
		input [2:0] pos;
		input       cause;
		begin
			set_bit = val;
			if (cause)
			begin
				set_bit[pos] = 1'b1;
			end
		end
	endfunction

	// ======================================================================
	// Completion request
	// A command in the same cycle as clear-status still arms
	always @*
	begin
		opc_live = opc_arm_r;
		if (cls_cmd_i)
		begin
			opc_live = 1'b0;
		end
		if (opc_cmd_i)
		begin
			opc_live = 1'b1;
		end
		opc_done_nxt = opc_live && ops_idle_i;
		opc_arm_nxt  = opc_live && !ops_idle_i;
	end

	// ======================================================================
	// Next value of the latch
	always @*
	begin
		evt_nxt = evt_r;
		// Clear first, so a same-cycle event still lands
		if (esr_query_i || cls_cmd_i)
		begin
			evt_nxt = 8'h00;
		end
		evt_nxt = set_bit(evt_nxt, 3'h`SESR_BIT_OPC, opc_done_nxt);
		evt_nxt = set_bit(evt_nxt, 3'h`SESR_BIT_RQC, req_ctrl_i);
		evt_nxt = set_bit(evt_nxt, 3'h`SESR_BIT_QYE, qry_no_data_i || qry_lost_i);
		evt_nxt = set_bit(evt_nxt, 3'h`SESR_BIT_DDE, dev_err_i);
		evt_nxt = set_bit(evt_nxt, 3'h`SESR_BIT_EXE, exe_range_err_i || exe_hw_err_i);
		evt_nxt = set_bit(evt_nxt, 3'h`SESR_BIT_CME,
			cmd_syntax_err_i || cmd_semantic_err_i || trig_in_msg_i);
		// Power-on is a one-shot at the first edge after reset release
		evt_nxt = set_bit(evt_nxt, 3'h`SESR_BIT_PON, !pon_seen_r);
		// User request has no source in this block
		evt_nxt[`SESR_BIT_URQ] = 1'b0;
	end

	// ======================================================================
	// Next value of enable and answer
	always @*
	begin
		ena_nxt        = ena_r;
		resp_valid_nxt = esr_query_i;
		resp_data_nxt  = resp_data_o;
		if (ena_wr_i)
		begin
			ena_nxt = ena_data_i;
		end
		// Capture the value held before the clearing edge
		if (esr_query_i)
		begin
			resp_data_nxt = pack_word(evt_r);
		end
	end

	// ======================================================================
	// Event registers
	always @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			evt_r      <= `SESR_EVT_RESET;
			opc_arm_r  <= 1'b0;
			pon_seen_r <= 1'b0;
		end
		else
		begin
			evt_r      <= evt_nxt;
			opc_arm_r  <= opc_arm_nxt;
			pon_seen_r <= 1'b1;
		end
	end

	// ======================================================================
	// Answer registers
	always @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			resp_valid_o <= 1'b0;
			resp_data_o  <= 16'h0000;
		end
		else
		begin
			resp_valid_o <= resp_valid_nxt;
			resp_data_o  <= resp_data_nxt;
		end
	end

	// ======================================================================
	// Enable register
	always @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			ena_r <= `SESR_ENA_RESET;
		end
		else
		begin
			ena_r <= ena_nxt;
		end
	end

	// ======================================================================
	// Outputs
	assign event_status_latch_o = pack_word(evt_r);
	assign enable_o             = ena_r;

	// ======================================================================
	// Status byte summary
	sesr_summary #(
		.W(`SESR_EVT_WIDTH)
	) u_sum (
		.events_i  (evt_r),
		.enable_i  (ena_r),
		.summary_o (stb_summary_o)
	);

endmodule

`default_nettype wire

//--- sim/sesr_chk.sv
/* Checker on the event latch ports.
 Assumes binding to sesr_event_latch. */
`default_nettype none
module sesr_chk (
	input wire logic        clock_i, sys_rst_i, dev_err_i, esr_query_i, cls_cmd_i, resp_valid_o, stb_summary_o,
	input wire logic        cmd_syntax_err_i, cmd_semantic_err_i, trig_in_msg_i, exe_range_err_i, exe_hw_err_i,
	input wire logic        qry_no_data_i, qry_lost_i, req_ctrl_i, opc_cmd_i, ops_idle_i,
	input wire logic [15:0] resp_data_o, event_status_latch_o,
	input wire logic [7:0]  enable_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	wire [15:0] l = event_status_latch_o;
	wire cme = cmd_syntax_err_i || cmd_semantic_err_i || trig_in_msg_i;
	wire exe = exe_range_err_i || exe_hw_err_i;
	wire qye = qry_no_data_i || qry_lost_i;
	wire [7:1] src = {2'b00, cme, exe, dev_err_i, qye, req_ctrl_i};
	sequence s_ans;
		resp_valid_o && resp_data_o == $past(l);
	endsequence
	property p_hi; l[15:8] == 8'h00 && resp_data_o[15:8] == 8'h00; endproperty
	a_hi: assert property (p_hi) else $error("upper bits");
	property p_u6; !l[6]; endproperty
	a_u6: assert property (p_u6) else $error("bit 6");
	property p_pon; $fell(sys_rst_i) |=> l[7]; endproperty
	a_pon: assert property (p_pon) else $error("power on");
	property p_dde; dev_err_i |=> l[3]; endproperty
	a_dde: assert property (p_dde) else $error("bit 3");
	property p_qry; esr_query_i |=> s_ans; endproperty
	a_qry: assert property (p_qry) else $error("answer");
	property p_vld; !esr_query_i |=> !resp_valid_o; endproperty
	a_vld: assert property (p_vld) else $error("answer pulse");
	property p_cme; cme |=> l[5]; endproperty
	a_cme: assert property (p_cme) else $error("bit 5");
	property p_exe; exe |=> l[4]; endproperty
	a_exe: assert property (p_exe) else $error("bit 4");
	property p_qye; qye |=> l[2]; endproperty
	a_qye: assert property (p_qye) else $error("bit 2");
	property p_rqc; req_ctrl_i |=> l[1]; endproperty
	a_rqc: assert property (p_rqc) else $error("bit 1");
	property p_opc; opc_cmd_i && ops_idle_i |=> l[0]; endproperty
	a_opc: assert property (p_opc) else $error("bit 0");
	property p_opc_src; $rose(l[0]) |-> $past(ops_idle_i); endproperty
	a_opc_src: assert property (p_opc_src) else $error("bit 0 source");
	property p_clr; (esr_query_i || cls_cmd_i) && !$fell(sys_rst_i) |=> l[15:1] == {8'h00, $past(src)}; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_stk; !esr_query_i && !cls_cmd_i |=> (l & $past(l)) == $past(l); endproperty
	a_stk: assert property (p_stk) else $error("sticky");
	property p_sum; stb_summary_o == |(l[7:0] & enable_o); endproperty
	a_sum: assert property (p_sum) else $error("summary");
endmodule
bind sesr_event_latch sesr_chk chk (.*);
`default_nettype wire

//--- sim/sesr_host.sv
/* Controller model: one-cycle command pulses, keeps last answer.
 Assumes requests change after the edge. */
`default_nettype none
module sesr_host (
	input wire logic        clock_i, q_i, c_i, rv_i,
	input wire logic [15:0] rd_i,
	output logic            q_o, c_o,
	output logic [15:0]     ans_o
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge clock_i)
	begin
		q_o <= q_i;
		c_o <= c_i;
		if (rv_i)
			ans_o <= rd_i;
	end
endmodule
`default_nettype wire

//--- sim/tb.sv
/* Bench for the event latch.
 Assumes the host model issues the query and clear-status commands. */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 0, sys_rst_i = 1, opc = 0, idle = 0, ew = 0, aq = 0, ac = 0;
	logic [8:0] ev = 0;
	logic [7:0] ena = 8'h00;
	wire q, c, rv, sum;
	wire [15:0] rd, ans, lat;
	wire [7:0] en;
	int err_total = 0, n_tests = 0;
	logic [7:0] exp_t [9] = '{8'h20, 8'h20, 8'h20, 8'h10, 8'h10, 8'h08, 8'h04, 8'h04, 8'h02};
	sesr_event_latch uut (.clock_i, .sys_rst_i, .cmd_syntax_err_i(ev[0]), .cmd_semantic_err_i(ev[1]),
		.trig_in_msg_i(ev[2]), .exe_range_err_i(ev[3]), .exe_hw_err_i(ev[4]), .dev_err_i(ev[5]),
		.qry_no_data_i(ev[6]), .qry_lost_i(ev[7]), .req_ctrl_i(ev[8]), .opc_cmd_i(opc), .ops_idle_i(idle),
		.esr_query_i(q), .cls_cmd_i(c), .ena_wr_i(ew), .ena_data_i(ena), .resp_valid_o(rv), .resp_data_o(rd),
		.event_status_latch_o(lat), .enable_o(en), .stb_summary_o(sum));
	sesr_host host (.clock_i, .q_i(aq), .c_i(ac), .rv_i(rv), .rd_i(rd), .q_o(q), .c_o(c), .ans_o(ans));
	task automatic chk(input logic [15:0] g, e);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %0t %h %h", $time, g, e);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clock_i);
		#2;
	endtask
	task automatic query;
		aq = 1;
		step(1);
		aq = 0;
		step(3);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial forever #12.5 clock_i = ~clock_i;
	initial
	begin
		#20000;
		err_total++;
		end_of_test;
	end
	initial
	begin
		step(5);
		sys_rst_i = 0;
		step(1);
		query;
		chk(ans, 16'h0080);
		foreach (exp_t[i])
		begin
			ev = 9'h001 << i;
			step(1);
			ev = 0;
			step(2);
			query;
			chk(ans, {8'h00, exp_t[i]});
			chk(lat, 16'h0000);
		end
		$display("events done");
		opc = 1;
		step(1);
		opc = 0;
		step(3);
		chk(lat, 16'h0000);
		idle = 1;
		step(2);
		chk(lat, 16'h0001);
		ena = 8'h08;
		ew = 1;
		ev = 9'h020;
		step(1);
		ew = 0;
		ev = 0;
		step(1);
		chk(sum, 16'h0001);
		chk({8'h00, en}, 16'h0008);
		ac = 1;
		step(1);
		ac = 0;
		step(4);
		chk(lat, 16'h0000);
		$display("opc and clear done");
		aq = 1;
		step(1);
		aq = 0;
		ev = 9'h020;
		step(1);
		ev = 0;
		step(2);
		chk(ans, 16'h0000);
		chk(lat, 16'h0008);
		query;
		chk(ans, 16'h0008);
		idle = 0;
		opc = 1;
		step(1);
		opc = 0;
		ac = 1;
		step(1);
		ac = 0;
		step(2);
		idle = 1;
		step(2);
		chk(lat, 16'h0000);
		sys_rst_i = 1;
		step(2);
		chk(lat, 16'h0000);
		chk({8'h00, en}, 16'h0000);
		sys_rst_i = 0;
		step(2);
		chk(lat, 16'h0080);
		$display("awkward cases done");
		end_of_test;
	end
endmodule
`default_nettype wire
